// ### core/dbf_pkg.sv
// Overview of operation
// - Gate interlock on source and gate sense
// - Overvoltage stops section, latched until disable
// - Below 90 percent drops power good
// - Below 70 percent after power good stops both sections
// - Power good low outside ten percent window
// - Thermal stop at 135, resume at 105
// - Thermal stop holds both power goods low
// - Current limit ends high-side pulse early
// - Aux driver needs enable, rail and reference
// - One-shot rectifier pulse when aux supply low
// - Switchover input above 4.5V feeds rail
// - Internal regulator on unless switchover input high
// - Reference on while any section enabled
// - Rail or reference fault stops both sections and aux driver
// - Each section runs only while enabled
// - Skip inhibit blocks pulse skipping
// - Power good falls at once on faults
// - Power good rise delayed by timing cap
// - Rectifier on after delay when disabled
// - Overvoltage turns rectifier on at once
// - Oscillator pulse sets latch, fall forces off
// - Zero current holds both switches off, except section two one-shot
package dbf_pkg;
    localparam int unsigned CLK_MHZ          = 125;
    localparam int unsigned OSC_KHZ          = 300;
    localparam int unsigned OSC_CYC          = CLK_MHZ * 1000 / OSC_KHZ;
    localparam int unsigned OSC_OFF_NS       = 300;
    localparam int unsigned OSC_OFF_CYC      = (OSC_OFF_NS * CLK_MHZ + 999) / 1000;
    localparam int unsigned ONESHOT_NS       = 1500;
    localparam int unsigned ONESHOT_CYC      = ONESHOT_NS * CLK_MHZ / 1000;
    localparam int unsigned DELAY_US_PER_NF  = 1500;
    localparam int unsigned DELAY_CYC_PER_NF = DELAY_US_PER_NF * CLK_MHZ;
    localparam logic [8:0]  OSC_LAST         = 9'(OSC_CYC - 1);
    localparam logic [8:0]  OSC_FALL         = 9'(OSC_CYC - OSC_OFF_CYC);
    localparam logic [7:0]  ONESHOT_LIM      = 8'(ONESHOT_CYC);
    localparam logic [3:0]  ADDR_CTRL        = 4'h0;
    localparam logic [3:0]  ADDR_STAT        = 4'h4;
    localparam int unsigned CTRL_CAP_LSB     = 0;
    localparam int unsigned CTRL_ONESHOT_BIT = 8;
    localparam logic [7:0]  CAP_RST          = 8'h0a;
    localparam logic        ONESHOT_RST      = 1'b0;
    localparam logic [1:0]  RESP_OKAY        = 2'h0;
    localparam logic [1:0]  RESP_SLVERR      = 2'h2;

    typedef struct packed {
        logic overvoltage;
        logic window_ok;
        logic light_uv;
        logic hard_uv;
        logic current_sense_over;
        logic loop_reset;
        logic zero_current;
        logic high_side_source_sense;
        logic low_side_gate_sense;
        logic light_load;
        logic feedback_low;
    } dbf_sect_cmp_s;

    typedef struct packed {
        logic therm_hot;
        logic therm_cool;
        logic five_volt_rail_ok;
        logic reference_ok;
        logic aux_supply_low;
        logic rail_switchover_high;
    } dbf_glob_cmp_s;

    typedef enum logic [2:0] {
        PH_OFF     = 3'b000,
        PH_WAIT_HS = 3'b001,
        PH_HS      = 3'b010,
        PH_WAIT_LS = 3'b011,
        PH_LS      = 3'b100,
        PH_ZERO    = 3'b101
    } dbf_phase_e;

    function automatic logic [31:0] dbf_delay_limit(input logic [7:0] cap,
                                                    input logic [31:0] per_nf);
        dbf_delay_limit = 32'(cap * per_nf);
    endfunction : dbf_delay_limit
endpackage : dbf_pkg

// ### core/dbf_sequencer.sv
// The placing of the registers and the AXI4-Lite register port were decided locally.
`timescale 1ns/10ps
module dbf_sequencer #(
    parameter logic [31:0] DELAY_PER_NF = 32'(dbf_pkg::DELAY_CYC_PER_NF)
) (
    input  wire logic                        aclk,
    input  wire logic                        aresetn,
    input  wire dbf_pkg::dbf_sect_cmp_s [1:0] sect_cmp_in,
    input  wire dbf_pkg::dbf_glob_cmp_s      glob_cmp_in,
    input  wire logic                        section_one_enable_in,
    input  wire logic                        section_two_enable_in,
    input  wire logic                        skip_inhibit_in,
    output logic                      [1:0]  hs_gate,
    output logic                      [1:0]  ls_gate,
    output logic                      [1:0]  power_good_out,
    output logic                      [1:0]  skip_allow,
    output logic                             aux_drv_en,
    output logic                             ref_en,
    output logic                             int_reg_en,
    output logic                             rail_from_switch,
    input  wire logic                 [3:0]  s_axi_awaddr,
    input  wire logic                        s_axi_awvalid,
    output logic                             s_axi_awready,
    input  wire logic                 [31:0] s_axi_wdata,
    input  wire logic                 [3:0]  s_axi_wstrb,
    input  wire logic                        s_axi_wvalid,
    output logic                             s_axi_wready,
    output logic                      [1:0]  s_axi_bresp,
    output logic                             s_axi_bvalid,
    input  wire logic                        s_axi_bready,
    input  wire logic                 [3:0]  s_axi_araddr,
    input  wire logic                        s_axi_arvalid,
    output logic                             s_axi_arready,
    output logic                      [31:0] s_axi_rdata,
    output logic                      [1:0]  s_axi_rresp,
    output logic                             s_axi_rvalid,
    input  wire logic                        s_axi_rready
);
    localparam int SW = 2 * $bits(dbf_pkg::dbf_sect_cmp_s) + $bits(dbf_pkg::dbf_glob_cmp_s) + 3;

    logic [SW-1:0]                  sync_q;
    dbf_pkg::dbf_sect_cmp_s [1:0]   sc;
    dbf_pkg::dbf_glob_cmp_s         gc;
    logic                           en1_s, en2_s, skip_inh_s;

    dbf_sync #(.W(SW)) u_sync (
        .aclk    (aclk),
        .aresetn (aresetn),
        .d       ({sect_cmp_in, glob_cmp_in, section_one_enable_in,
                   section_two_enable_in, skip_inhibit_in}),
        .q       (sync_q)
    );
    assign {sc, gc, en1_s, en2_s, skip_inh_s} = sync_q;

    // Oscillator divider
    logic [8:0] osc_cnt_ff, nxt_osc_cnt;
    logic       osc_pulse, osc_fall;
    always_comb begin
        nxt_osc_cnt = (osc_cnt_ff == dbf_pkg::OSC_LAST) ? 9'h000 : osc_cnt_ff + 9'h001;
        osc_pulse   = (osc_cnt_ff == 9'h000);
        osc_fall    = (osc_cnt_ff == dbf_pkg::OSC_FALL);
    end
    always_ff @(posedge aclk) begin
        if (!aresetn) osc_cnt_ff <= 9'h000;
        else          osc_cnt_ff <= nxt_osc_cnt;
    end

    // Register file state
    logic [7:0]  cap_ff, nxt_cap;
    logic        os_en_ff, nxt_os_en;
    logic        aw_got_ff, nxt_aw_got, w_got_ff, nxt_w_got;
    logic [3:0]  awaddr_ff, nxt_awaddr;
    logic [31:0] wdata_ff, nxt_wdata;
    logic [3:0]  wstrb_ff, nxt_wstrb;
    logic        awready_ff, nxt_awready, wready_ff, nxt_wready;
    logic        bvalid_ff, nxt_bvalid, arready_ff, nxt_arready, rvalid_ff, nxt_rvalid;
    logic [1:0]  bresp_ff, nxt_bresp, rresp_ff, nxt_rresp;
    logic [31:0] rdata_ff, nxt_rdata, status;

    // Supervision and drive state
    logic [1:0]         ovp_ff, nxt_ovp, huv_ff, nxt_huv, armed_ff, nxt_armed;
    logic [1:0]         pg_ff, nxt_pg, hs_ff, nxt_hs, ls_ff, nxt_ls;
    logic [1:0]         skip_ff, nxt_skip, run, good, en;
    logic [31:0]        pgcnt_ff [2];
    logic [31:0]        nxt_pgcnt [2];
    logic [31:0]        offcnt_ff [2];
    logic [31:0]        nxt_offcnt [2];
    dbf_pkg::dbf_phase_e ph_ff [2];
    dbf_pkg::dbf_phase_e nxt_ph [2];
    logic [7:0]         oscnt_ff, nxt_oscnt;
    logic               os_done_ff, nxt_os_done, os_act;
    logic               therm_ff, nxt_therm, stop_all;
    logic               aux_ff, nxt_aux, ref_ff, nxt_ref, ireg_ff, nxt_ireg, rsw_ff, nxt_rsw;
    logic [31:0]        lim;

    assign status = {24'h000000, therm_ff, huv_ff, ovp_ff, run[1] | run[0], pg_ff};

    always_comb begin
        nxt_aw_got  = aw_got_ff | (s_axi_awvalid & awready_ff);
        nxt_w_got   = w_got_ff | (s_axi_wvalid & wready_ff);
        nxt_awaddr  = (s_axi_awvalid & awready_ff) ? s_axi_awaddr : awaddr_ff;
        nxt_wdata   = (s_axi_wvalid & wready_ff) ? s_axi_wdata : wdata_ff;
        nxt_wstrb   = (s_axi_wvalid & wready_ff) ? s_axi_wstrb : wstrb_ff;
        nxt_bvalid  = bvalid_ff & ~s_axi_bready;
        nxt_bresp   = bresp_ff;
        nxt_cap     = cap_ff;
        nxt_os_en   = os_en_ff;
        // Both halves held until the response is free, so either order works
        if (aw_got_ff & w_got_ff & ~bvalid_ff) begin
            nxt_aw_got = 1'b0;
            nxt_w_got  = 1'b0;
            nxt_bvalid = 1'b1;
            nxt_bresp  = dbf_pkg::RESP_OKAY;
            if (awaddr_ff[3:2] == dbf_pkg::ADDR_CTRL[3:2]) begin
                if (wstrb_ff[0]) nxt_cap = wdata_ff[dbf_pkg::CTRL_CAP_LSB +: 8];
                if (wstrb_ff[1]) nxt_os_en = wdata_ff[dbf_pkg::CTRL_ONESHOT_BIT];
            end else if (awaddr_ff[3:2] == dbf_pkg::ADDR_STAT[3:2]) begin
                nxt_bresp = dbf_pkg::RESP_OKAY;
            end else begin
                nxt_bresp = dbf_pkg::RESP_SLVERR;
            end
        end
        nxt_awready = ~nxt_aw_got & ~nxt_bvalid;
        nxt_wready  = ~nxt_w_got & ~nxt_bvalid;
        nxt_rvalid  = rvalid_ff & ~s_axi_rready;
        nxt_rdata   = rdata_ff;
        nxt_rresp   = rresp_ff;
        if (s_axi_arvalid & arready_ff) begin
            nxt_rvalid = 1'b1;
            nxt_rresp  = dbf_pkg::RESP_OKAY;
            if (s_axi_araddr[3:2] == dbf_pkg::ADDR_CTRL[3:2]) begin
                nxt_rdata = {23'h000000, os_en_ff, cap_ff};
            end else if (s_axi_araddr[3:2] == dbf_pkg::ADDR_STAT[3:2]) begin
                nxt_rdata = status;
            end else begin
                nxt_rdata = 32'h00000000;
                nxt_rresp = dbf_pkg::RESP_SLVERR;
            end
        end
        nxt_arready = ~nxt_rvalid;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_got_ff  <= 1'b0;
            w_got_ff   <= 1'b0;
            awaddr_ff  <= 4'h0;
            wdata_ff   <= 32'h00000000;
            wstrb_ff   <= 4'h0;
            awready_ff <= 1'b0;
            wready_ff  <= 1'b0;
            bvalid_ff  <= 1'b0;
            bresp_ff   <= dbf_pkg::RESP_OKAY;
            arready_ff <= 1'b0;
            rvalid_ff  <= 1'b0;
            rdata_ff   <= 32'h00000000;
            rresp_ff   <= dbf_pkg::RESP_OKAY;
            cap_ff     <= dbf_pkg::CAP_RST;
            os_en_ff   <= dbf_pkg::ONESHOT_RST;
        end else begin
            aw_got_ff  <= nxt_aw_got;
            w_got_ff   <= nxt_w_got;
            awaddr_ff  <= nxt_awaddr;
            wdata_ff   <= nxt_wdata;
            wstrb_ff   <= nxt_wstrb;
            awready_ff <= nxt_awready;
            wready_ff  <= nxt_wready;
            bvalid_ff  <= nxt_bvalid;
            bresp_ff   <= nxt_bresp;
            arready_ff <= nxt_arready;
            rvalid_ff  <= nxt_rvalid;
            rdata_ff   <= nxt_rdata;
            rresp_ff   <= nxt_rresp;
            cap_ff     <= nxt_cap;
            os_en_ff   <= nxt_os_en;
        end
    end

    always_comb begin
        lim       = dbf_pkg::dbf_delay_limit(cap_ff, DELAY_PER_NF);
        en        = {en2_s, en1_s};
        nxt_therm = gc.therm_hot | (therm_ff & ~gc.therm_cool);
        stop_all  = therm_ff | ~gc.five_volt_rail_ok | ~gc.reference_ok
                    | huv_ff[0] | huv_ff[1];
        nxt_aux   = (en1_s | en2_s) & gc.five_volt_rail_ok & gc.reference_ok;
        nxt_ref   = en1_s | en2_s;
        // Regulator stays up with no section running; only switchover idles it
        nxt_ireg  = ~gc.rail_switchover_high;
        nxt_rsw   = gc.rail_switchover_high;
        os_act    = 1'b0;
        nxt_oscnt = 8'h00;
        nxt_os_done = os_done_ff & ~osc_pulse;
        for (int i = 0; i < 2; i++) begin
            run[i]       = en[i] & ~ovp_ff[i] & ~stop_all;
            nxt_ovp[i]   = en[i] & (ovp_ff[i] | sc[i].overvoltage);
            nxt_armed[i] = en[i] & (armed_ff[i] | pg_ff[i]);
            // Hard undervoltage is only armed once the output has been good
            nxt_huv[i]   = en[i] & (huv_ff[i] | (sc[i].hard_uv & armed_ff[i]));
            good[i]      = run[i] & sc[i].window_ok & ~sc[i].light_uv & ~sc[i].hard_uv;
            nxt_pgcnt[i] = good[i] ? ((pgcnt_ff[i] < lim) ? pgcnt_ff[i] + 32'h1 : lim) : 32'h0;
            // Next thermal state, so power good drops with the shutdown itself
            nxt_pg[i]    = good[i] & ~nxt_therm & (pgcnt_ff[i] >= lim);
            nxt_offcnt[i] = (~run[i] & ~ovp_ff[i] & (~en[i] | therm_ff))
                            ? ((offcnt_ff[i] < lim) ? offcnt_ff[i] + 32'h1 : lim) : 32'h0;
            nxt_skip[i]  = run[i] & ~skip_inh_s & sc[i].light_load;
            nxt_ph[i]    = ph_ff[i];
            if (!run[i]) begin
                nxt_ph[i] = dbf_pkg::PH_OFF;
            end else if (osc_pulse & (~nxt_skip[i] | sc[i].feedback_low)) begin
                nxt_ph[i] = dbf_pkg::PH_WAIT_HS;
            end else begin
                case (ph_ff[i])
                    dbf_pkg::PH_OFF: nxt_ph[i] = dbf_pkg::PH_ZERO;
                    dbf_pkg::PH_WAIT_HS: begin
                        if (osc_fall) nxt_ph[i] = dbf_pkg::PH_WAIT_LS;
                        else if (~ls_ff[i] & sc[i].low_side_gate_sense)
                            nxt_ph[i] = dbf_pkg::PH_HS;
                    end
                    dbf_pkg::PH_HS: begin
                        if (sc[i].current_sense_over | sc[i].loop_reset | osc_fall)
                            nxt_ph[i] = dbf_pkg::PH_WAIT_LS;
                    end
                    dbf_pkg::PH_WAIT_LS: begin
                        if (sc[i].zero_current) nxt_ph[i] = dbf_pkg::PH_ZERO;
                        else if (~hs_ff[i] & sc[i].high_side_source_sense)
                            nxt_ph[i] = dbf_pkg::PH_LS;
                    end
                    dbf_pkg::PH_LS: begin
                        if (sc[i].zero_current) nxt_ph[i] = dbf_pkg::PH_ZERO;
                    end
                    default: nxt_ph[i] = dbf_pkg::PH_ZERO;
                endcase
            end
        end
        // One-shot only on section two, once per oscillator period
        os_act = run[1] & os_en_ff & gc.aux_supply_low & ~os_done_ff & ~osc_pulse
                 & (ph_ff[1] == dbf_pkg::PH_ZERO) & (nxt_ph[1] == dbf_pkg::PH_ZERO);
        if (os_act) begin
            nxt_oscnt = oscnt_ff + 8'h01;
            if (nxt_oscnt == dbf_pkg::ONESHOT_LIM) nxt_os_done = 1'b1;
        end
        for (int i = 0; i < 2; i++) begin
            // A fresh overvoltage cuts the high side at once, not a cycle later
            nxt_hs[i] = run[i] & ~nxt_ovp[i] & (nxt_ph[i] == dbf_pkg::PH_HS);
            if (run[i])
                nxt_ls[i] = (nxt_ph[i] == dbf_pkg::PH_LS) | ((i == 1) & os_act);
            else
                nxt_ls[i] = ovp_ff[i] | (offcnt_ff[i] >= lim & (~en[i] | therm_ff));
        end
    end

    // Synchronous reset stands in for supply removal
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ovp_ff <= 2'b00; huv_ff <= 2'b00; armed_ff <= 2'b00; pg_ff <= 2'b00;
            hs_ff <= 2'b00; ls_ff <= 2'b00; skip_ff <= 2'b00;
            for (int i = 0; i < 2; i++) begin
                pgcnt_ff[i]  <= 32'h0;
                offcnt_ff[i] <= 32'h0;
                ph_ff[i]     <= dbf_pkg::PH_OFF;
            end
            oscnt_ff <= 8'h00; os_done_ff <= 1'b0; therm_ff <= 1'b0;
            aux_ff <= 1'b0; ref_ff <= 1'b0; ireg_ff <= 1'b1; rsw_ff <= 1'b0;
        end else begin
            ovp_ff <= nxt_ovp; huv_ff <= nxt_huv; armed_ff <= nxt_armed; pg_ff <= nxt_pg;
            hs_ff <= nxt_hs; ls_ff <= nxt_ls; skip_ff <= nxt_skip;
            for (int i = 0; i < 2; i++) begin
                pgcnt_ff[i]  <= nxt_pgcnt[i];
                offcnt_ff[i] <= nxt_offcnt[i];
                ph_ff[i]     <= nxt_ph[i];
            end
            oscnt_ff <= nxt_oscnt; os_done_ff <= nxt_os_done; therm_ff <= nxt_therm;
            aux_ff <= nxt_aux; ref_ff <= nxt_ref; ireg_ff <= nxt_ireg; rsw_ff <= nxt_rsw;
        end
    end

    assign hs_gate = hs_ff;
    assign ls_gate = ls_ff;
    assign power_good_out = pg_ff;
    assign skip_allow = skip_ff;
    assign aux_drv_en = aux_ff;
    assign ref_en = ref_ff;
    assign int_reg_en = ireg_ff;
    assign rail_from_switch = rsw_ff;
    assign s_axi_awready = awready_ff;
    assign s_axi_wready = wready_ff;
    assign s_axi_bvalid = bvalid_ff;
    assign s_axi_bresp = bresp_ff;
    assign s_axi_arready = arready_ff;
    assign s_axi_rvalid = rvalid_ff;
    assign s_axi_rdata = rdata_ff;
    assign s_axi_rresp = rresp_ff;

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    sequence s_ovp_event;
        sc[0].overvoltage && en1_s && !ovp_ff[0];
    endsequence
    sequence s_crowbar;
        ovp_ff[0] ##0 !hs_ff[0] ##1 ls_ff[0];
    endsequence

    a_hs_interlock: assert property ($rose(hs_ff[0]) |->
        $past(!ls_ff[0] && sc[0].low_side_gate_sense)) else $error("high side on too early");
    a_ls_interlock: assert property ($rose(ls_ff[0]) && run[0] |->
        $past(!hs_ff[0] && sc[0].high_side_source_sense)) else $error("low side on too early");
    a_ovp_latch: assert property (s_ovp_event |=> s_crowbar)
        else $error("overvoltage not latched");
    a_ovp_hold: assert property (ovp_ff[0] && en1_s |=> ovp_ff[0])
        else $error("overvoltage latch dropped");
    a_pg_light_uv: assert property (sc[0].light_uv |=> !pg_ff[0])
        else $error("power good high in undervoltage");
    a_huv_both: assert property (huv_ff[1] |=> !hs_ff[0] && !hs_ff[1])
        else $error("switching during hard undervoltage");
    a_pg_window: assert property (!sc[1].window_ok |=> !pg_ff[1])
        else $error("power good high outside window");
    a_therm_stop: assert property (gc.therm_hot |=> ##1 !hs_ff[0] && !hs_ff[1] && pg_ff == 2'b00)
        else $error("thermal stop ignored");
    a_cur_limit: assert property (hs_ff[0] && sc[0].current_sense_over |=> !hs_ff[0])
        else $error("current limit ignored");
    a_aux_gate: assert property (aux_drv_en |-> $past(en1_s || en2_s))
        else $error("aux driver without enable");
    a_oneshot_len: assert property (oscnt_ff <= dbf_pkg::ONESHOT_LIM)
        else $error("one-shot too long");
    a_pg_delay: assert property ($rose(pg_ff[0]) |-> $past(good[0] && pgcnt_ff[0] >= lim))
        else $error("power good rose before delay");
    a_pg_window_one: assert property (!sc[0].window_ok |=> !pg_ff[0])
        else $error("power good high outside window");
    a_huv_any: assert property (huv_ff[0] |=> !hs_ff[0] && !hs_ff[1])
        else $error("switching during hard undervoltage");
    a_pg_therm: assert property (therm_ff |-> pg_ff == 2'b00)
        else $error("power good high in thermal stop");
    a_ref_enable: assert property (ref_ff == $past(en1_s || en2_s))
        else $error("reference enable wrong");
    a_reg_switch: assert property (ireg_ff == !$past(gc.rail_switchover_high))
        else $error("internal regulator state wrong");
    a_skip_block: assert property (skip_inh_s |=> skip_ff == 2'b00)
        else $error("pulse skipping while inhibited");
    a_aux_rail: assert property (aux_ff |-> $past(gc.five_volt_rail_ok && gc.reference_ok))
        else $error("aux driver without rail");
    a_stop_all: assert property (stop_all |=> hs_ff == 2'b00)
        else $error("switching while stopped");
endmodule : dbf_sequencer

// ### core/dbf_sync.sv
`timescale 1ns/10ps
module dbf_sync #(
    parameter int W = 8
) (
    input  wire logic         aclk,
    input  wire logic         aresetn,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    logic [W-1:0] meta_ff;
    logic [W-1:0] q_ff;

    // First stage feeds only the second stage
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            meta_ff <= '0;
            q_ff    <= '0;
        end else begin
            meta_ff <= d;
            q_ff    <= meta_ff;
        end
    end

    assign q = q_ff;
endmodule : dbf_sync

// ### tb/dbf_fets.sv
`timescale 1ns/10ps
module dbf_fets (
    input  wire logic       aclk,
    input  wire logic       slow,
    input  wire logic [1:0] hs_gate,
    input  wire logic [1:0] ls_gate,
    output logic      [1:0] hs_src_high,
    output logic      [1:0] ls_gate_high
);
    // Gate charge needs 1 or 4 cycles to cross the sense thresholds
    logic [3:0][3:0] dly_ff;
    always_ff @(posedge aclk) begin
        dly_ff <= {dly_ff[2:0], ls_gate, hs_gate};
    end
    assign hs_src_high  = slow ? dly_ff[3][1:0] : dly_ff[0][1:0];
    assign ls_gate_high = slow ? dly_ff[3][3:2] : dly_ff[0][3:2];
endmodule : dbf_fets

// ### tb/dbf_sequencer_test.sv
`timescale 1ns/10ps
module dbf_sequencer_test;
    localparam logic [1:0] OK = dbf_pkg::RESP_OKAY;
    localparam logic [1:0] SE = dbf_pkg::RESP_SLVERR;
    dbf_pkg::dbf_sect_cmp_s [1:0] sc, sci;
    dbf_pkg::dbf_glob_cmp_s       gc;
    logic        aclk = 0, aresetn = 0, en1 = 0, en2 = 0, skip_inh = 0, slow = 0;
    logic [1:0]  hs_gate, ls_gate, pg, skip_allow, hs_src, ls_sns, bresp, rresp;
    logic        aux_drv_en, ref_en, int_reg_en, rail_sw;
    logic [3:0]  awaddr = 0, araddr = 0;
    logic [31:0] wdata = 0, rdata;
    logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic        awready, wready, bvalid, arready, rvalid;
    logic [33:0] rq[$];
    logic [1:0]  bq[$];
    logic [7:0]  cap;
    int          err_total = 0, cmp_count = 0, run_len, max_len;
    always #4 aclk = ~aclk;
    always_comb begin
        sci = sc;
        for (int k = 0; k < 2; k++) begin
            sci[k].high_side_source_sense = hs_src[k];
            sci[k].low_side_gate_sense    = ls_sns[k];
        end
    end
    dbf_fets dbf_fets_i (.aclk(aclk), .slow(slow), .hs_gate(hs_gate), .ls_gate(ls_gate),
        .hs_src_high(hs_src), .ls_gate_high(ls_sns));
    dbf_sequencer #(.DELAY_PER_NF(32'd4)) dbf_sequencer_i (.aclk(aclk), .aresetn(aresetn),
        .sect_cmp_in(sci), .glob_cmp_in(gc), .section_one_enable_in(en1),
        .section_two_enable_in(en2), .skip_inhibit_in(skip_inh), .hs_gate(hs_gate),
        .ls_gate(ls_gate), .power_good_out(pg), .skip_allow(skip_allow),
        .aux_drv_en(aux_drv_en), .ref_en(ref_en), .int_reg_en(int_reg_en),
        .rail_from_switch(rail_sw), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
    task automatic chk(input string n, input logic [33:0] s, input logic [33:0] e);
        cmp_count++;
        if (s !== e) begin
            err_total++;
            $display("mismatch %s expected %h seen %h", n, e, s);
        end
    endtask : chk
    task automatic nap(input int n);
        repeat (n) @(posedge aclk);
    endtask : nap
    task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] r);
        bq.push_back(r);
        awaddr  <= a;
        wdata   <= d;
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        @(posedge aclk);
        while (awvalid || wvalid) begin
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
            @(posedge aclk);
        end
        while (!bvalid) @(posedge aclk);
        bready <= 1'b0;
    endtask : wr
    task automatic rd(input logic [3:0] a, input logic [31:0] d, input logic [1:0] r);
        rq.push_back({r, d});
        araddr  <= a;
        arvalid <= 1'b1;
        rready  <= 1'b1;
        @(posedge aclk);
        while (!arready) @(posedge aclk);
        arvalid <= 1'b0;
        @(posedge aclk);
        while (!rvalid) @(posedge aclk);
        rready <= 1'b0;
    endtask : rd
    // Responses are matched in order against the notes left by the drivers
    always @(posedge aclk) begin
        if (bvalid && bready) chk("bresp", bresp, bq.pop_front());
        if (rvalid && rready) chk("rdata", {rresp, rdata}, rq.pop_front());
    end
    task automatic end_of_test;
        $display("comparisons %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : end_of_test
    initial begin
        repeat (20000) @(posedge aclk);
        err_total++;
        end_of_test();
    end
    initial begin
        sc = '0;
        gc = '0;
        gc.therm_cool = 1'b1;
        gc.five_volt_rail_ok = 1'b1;
        gc.reference_ok = 1'b1;
        void'($urandom(11));
        nap(4);
        aresetn <= 1'b1;
        @(posedge aclk);
        chk("int_reg_en", int_reg_en, 1);
        chk("ref_en", ref_en, 0);
        chk("pg", pg, 0);
        rd(4'h0, 32'h0a, OK);
        wr(4'h8, $urandom, SE);
        rd(4'hc, 32'h0, SE);
        cap = 8'($urandom_range(3, 1));
        wr(4'h0, {16'($urandom), 8'h0, cap}, OK);
        rd(4'h0, {24'h0, cap}, OK);
        wr(4'h4, $urandom, OK);
        $display("test registers done");
        slow <= 1'($urandom);
        en1 <= 1'b1;
        sc[0].window_ok <= 1'b1;
        sc[0].light_load <= 1'b1;
        skip_inh <= 1'b1;
        nap(5);
        chk("ref_en", ref_en, 1);
        chk("aux", aux_drv_en, 1);
        chk("skip", skip_allow[0], 0);
        chk("pg_early", pg[0], 0);
        nap(cap * 4 + 4);
        chk("pg_late", pg[0], 1);
        rd(4'h4, 32'h05, OK);
        skip_inh <= 1'b0;
        nap(5);
        chk("skip", skip_allow[0], 1);
        sc[0].light_load <= 1'b0;
        for (int f = 0; f < 2; f++) begin
            if (f == 0) sc[0].light_uv <= 1'b1;
            else sc[0].window_ok <= 1'b0;
            nap(4);
            chk("pg_fault", pg[0], 0);
            rd(4'h4, 32'h04, OK);
            sc[0].light_uv <= 1'b0;
            sc[0].window_ok <= 1'b1;
            nap(cap * 4 + 8);
            chk("pg_back", pg[0], 1);
        end
        $display("test power good done");
        gc.therm_hot <= 1'b1;
        gc.therm_cool <= 1'b0;
        nap(4);
        chk("pg_therm", pg, 0);
        gc.therm_hot <= 1'b0;
        nap(cap * 4 + 6);
        chk("ls_therm", ls_gate[0], 1);
        rd(4'h4, 32'h80, OK);
        gc.therm_cool <= 1'b1;
        nap(cap * 4 + 10);
        chk("pg_cool", pg[0], 1);
        $display("test thermal done");
        sc[0].overvoltage <= 1'b1;
        nap(5);
        chk("ls_crowbar", ls_gate[0], 1);
        chk("hs_ovp", hs_gate[0], 0);
        sc[0].overvoltage <= 1'b0;
        nap(6);
        rd(4'h4, 32'h08, OK);
        en1 <= 1'b0;
        nap(5);
        en1 <= 1'b1;
        nap(cap * 4 + 10);
        rd(4'h4, 32'h05, OK);
        sc[0].hard_uv <= 1'b1;
        nap(5);
        chk("gates_huv", {hs_gate, ls_gate}, 4'h2);
        rd(4'h4, 32'h20, OK);
        sc[0].hard_uv <= 1'b0;
        $display("test latched faults done");
        gc.rail_switchover_high <= 1'b1;
        gc.five_volt_rail_ok <= 1'b0;
        nap(5);
        chk("rail_sw", rail_sw, 1);
        chk("reg_off", int_reg_en, 0);
        chk("hs_rail", hs_gate, 0);
        chk("aux_rail", aux_drv_en, 0);
        gc.five_volt_rail_ok <= 1'b1;
        gc.rail_switchover_high <= 1'b0;
        en1 <= 1'b0;
        nap(5);
        chk("ref_off", ref_en, 0);
        chk("reg_on", int_reg_en, 1);
        chk("pg_off", pg, 0);
        $display("test rails done");
        wr(4'h0, {23'h0, 1'b1, cap}, OK);
        gc.aux_supply_low <= 1'b1;
        sc[1].light_load <= 1'b1;
        en2 <= 1'b1;
        nap(10);
        run_len = 0;
        max_len = 0;
        // Spans two oscillator periods so at least one whole pulse is seen
        repeat (900) begin
            @(posedge aclk);
            run_len = ls_gate[1] ? run_len + 1 : 0;
            if (run_len > max_len) max_len = run_len;
        end
        chk("oneshot_len", max_len, dbf_pkg::ONESHOT_CYC);
        $display("test one-shot done");
        end_of_test();
    end
endmodule : dbf_sequencer_test
